/* frs_host.sv */
// Bus master model standing in for the host processor
`timescale 1ns/1ns
module frs_host (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    // Idle bus at time zero
    initial begin
        {hsel, haddr, htrans, hwrite} = '0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // One single word transfer, held until hready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~haddr;
        hwdata <= w ? wd : ~hwdata;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        // Released data lines do not keep the last value
        hwdata <= ~hwdata;
    endtask
endmodule

/* frs_pkg.sv */
// Package of offsets, field positions and reset values for the frame status readback block
package frs_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_TX_CONFIG     = 8'h00;
    localparam logic [7:0] OFS_COUNT_LOW     = 8'h04;
    localparam logic [7:0] OFS_STATUS_HIGH   = 8'h08;
    localparam logic [7:0] OFS_EXT_FEATURE   = 8'h0c;
    localparam logic [7:0] OFS_INT_STATUS    = 8'h10;
    localparam logic [7:0] OFS_INT_MASK      = 8'h14;

    // ==========================================================
    // Field positions
    localparam int TXC_DTR_BIT        = 7;
    localparam int TXC_LEN_HI         = 6;
    localparam int TXC_LEN_LO         = 5;
    localparam int TXC_BREAK_BIT      = 4;
    localparam int TXC_ENABLE_BIT     = 3;
    localparam int TXC_CRC_SEL_BIT    = 2;
    localparam int TXC_RTS_BIT        = 1;
    localparam int TXC_CRC_EN_BIT     = 0;
    localparam int FSH_OVERFLOW_BIT   = 7;
    localparam int FSH_SOURCE_BIT     = 6;
    localparam int EXT_COUNT_GATE_BIT = 2;
    localparam int IRQ_OVERFLOW_BIT   = 0;
    localparam int IRQ_FRAME_BIT      = 1;
    localparam int IRQ_WIDTH          = 2;
    localparam int COUNT_WIDTH        = 14;
    localparam int COUNT_LOW_WIDTH    = 8;

    // ==========================================================
    // Character length codes in the transmit configuration
    localparam logic [1:0] LEN_CODE_5 = 2'h0;
    localparam logic [1:0] LEN_CODE_7 = 2'h1;
    localparam logic [1:0] LEN_CODE_6 = 2'h2;
    localparam logic [1:0] LEN_CODE_8 = 2'h3;

    // ==========================================================
    // Reset values
    localparam logic [7:0]  RST_EXT_FEATURE = 8'h00;
    localparam logic [1:0]  RST_INT_MASK    = 2'h0;
    localparam logic [13:0] RST_BYTE_COUNT  = 14'h0000;
    localparam logic [31:0] RST_RDATA       = 32'h0000_0000;

    // Bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_BUSY = 2'b10
    } frs_bus_state_t;

endpackage

/* frs_readback.sv */
// Frame status readback registers of one serial channel, AHB-Lite slave
//
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
module frs_readback
    import frs_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    output logic             count_gate,
    input  wire logic        tx_dtr,
    input  wire logic [3:0]  tx_char_bits,
    input  wire logic        tx_send_break,
    input  wire logic        tx_enable,
    input  wire logic        tx_crc16_sel,
    input  wire logic        tx_rts,
    input  wire logic        tx_crc_enable,
    input  wire logic [13:0] frame_byte_count,
    input  wire logic        frame_done,
    input  wire logic        status_fifo_overflow,
    input  wire logic        status_fifo_available,
    input  wire logic [7:0]  vector_readback,
    input  wire logic [7:0]  pending_interrupt_readback
);

    // ==========================================================
    // Declarations
    frs_bus_state_t    state_q;
    frs_bus_state_t    state_d;
    logic [7:0]        addr_q;
    logic [7:0]        addr_d;
    logic              write_q;
    logic              write_d;
    logic              ready_q;
    logic              ready_d;
    logic [31:0]       rdata_q;
    logic [31:0]       rdata_d;
    logic              resp_q;
    logic [7:0]        ext_feature_control_q;
    logic [7:0]        ext_feature_control_d;
    logic [IRQ_WIDTH-1:0] int_mask_q;
    logic [IRQ_WIDTH-1:0] int_mask_d;
    logic [IRQ_WIDTH-1:0] int_status;
    logic [IRQ_WIDTH-1:0] int_set;
    logic [IRQ_WIDTH-1:0] int_clear;
    logic              irq_q;
    logic              irq_d;
    logic              gate_q;
    logic              gate_d;
    logic [COUNT_WIDTH-1:0] byte_count_q;
    logic [COUNT_WIDTH-1:0] byte_count_d;
    logic              overflow_q;
    logic              overflow_d;
    logic              available_q;
    logic              available_d;
    logic [1:0]        len_code;
    logic [7:0]        tx_config_value;
    logic [7:0]        count_low_value;
    logic [7:0]        status_high_value;
    logic [7:0]        read_value;
    logic              addr_take;
    logic              data_write;

    // ==========================================================
    // Elaboration checks
    if (COUNT_WIDTH - COUNT_LOW_WIDTH != 6 || IRQ_WIDTH != 2) begin : g_bad_widths
        $error("frs_readback: count split and interrupt width must match the register layout");
    end

    // ==========================================================
    // Address phase capture
    assign addr_take  = hsel & hready & htrans[1] & (state_q == BUS_IDLE);
    assign data_write = (state_q == BUS_BUSY) & write_q;

    // Bus slave next state: one wait state for every transfer
    always_comb begin
        state_d = state_q;
        addr_d  = addr_q;
        write_d = write_q;
        ready_d = ready_q;
        rdata_d = rdata_q;
        unique case (state_q)
            BUS_IDLE: begin
                ready_d = 1'b1;
                if (addr_take) begin
                    addr_d  = {haddr[7:2], 2'b00};
                    write_d = hwrite;
                    ready_d = 1'b0;
                    state_d = BUS_BUSY;
                end
            end
            BUS_BUSY: begin
                ready_d = 1'b1;
                rdata_d = write_q ? RST_RDATA : {24'h00_0000, read_value};
                state_d = BUS_IDLE;
            end
            default: begin
                state_d = BUS_IDLE;
                ready_d = 1'b1;
            end
        endcase
    end

    // Bus slave registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= BUS_IDLE;
            addr_q  <= 8'h00;
            write_q <= 1'b0;
            ready_q <= 1'b1;
            rdata_q <= RST_RDATA;
            resp_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            addr_q  <= addr_d;
            write_q <= write_d;
            ready_q <= ready_d;
            rdata_q <= rdata_d;
            resp_q  <= 1'b0;
        end
    end

    // ==========================================================
    // Transmit configuration readback
    // length code mapping
    always_comb begin
        if (tx_char_bits <= 4'h5) begin
            len_code = LEN_CODE_5;
        end else if (tx_char_bits == 4'h6) begin
            len_code = LEN_CODE_6;
        end else if (tx_char_bits == 4'h7) begin
            len_code = LEN_CODE_7;
        end else begin
            len_code = LEN_CODE_8;
        end
    end

    // Assemble the configuration byte
    always_comb begin
        tx_config_value                  = 8'h00;
        tx_config_value[TXC_DTR_BIT]     = tx_dtr;
        tx_config_value[TXC_LEN_HI:TXC_LEN_LO] = len_code;
        tx_config_value[TXC_BREAK_BIT]   = tx_send_break;
        tx_config_value[TXC_ENABLE_BIT]  = tx_enable;
        tx_config_value[TXC_CRC_SEL_BIT] = tx_crc16_sel;
        tx_config_value[TXC_RTS_BIT]     = tx_rts;
        tx_config_value[TXC_CRC_EN_BIT]  = tx_crc_enable;
    end

    // ==========================================================
    // Frame count and FIFO status capture
    always_comb begin
        byte_count_d = frame_done ? frame_byte_count : byte_count_q;
        overflow_d   = status_fifo_overflow;
        available_d  = status_fifo_available;
    end

    // Captured core status
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            byte_count_q <= RST_BYTE_COUNT;
            overflow_q   <= 1'b0;
            available_q  <= 1'b0;
        end else begin
            byte_count_q <= byte_count_d;
            overflow_q   <= overflow_d;
            available_q  <= available_d;
        end
    end

    // Count readback bytes
    always_comb begin
        count_low_value   = byte_count_q[COUNT_LOW_WIDTH-1:0];
        status_high_value = {2'b00, byte_count_q[COUNT_WIDTH-1:COUNT_LOW_WIDTH]};
        status_high_value[FSH_OVERFLOW_BIT] = ~overflow_q;
        status_high_value[FSH_SOURCE_BIT]   = ~available_q;
    end

    // ==========================================================
    // Read data selection
    always_comb begin
        read_value = 8'h00;
        unique case (addr_q)
            OFS_TX_CONFIG: begin
                read_value = tx_config_value;
            end
            OFS_COUNT_LOW: begin
                read_value = gate_q ? count_low_value : vector_readback;
            end
            OFS_STATUS_HIGH: begin
                read_value = gate_q ? status_high_value : pending_interrupt_readback;
            end
            OFS_EXT_FEATURE: begin
                read_value = ext_feature_control_q;
            end
            OFS_INT_STATUS: begin
                read_value = {6'h00, int_status};
            end
            OFS_INT_MASK: begin
                read_value = {6'h00, int_mask_q};
            end
            default: begin
                read_value = 8'h00;
            end
        endcase
    end

    // ==========================================================
    // Software control registers
    always_comb begin
        ext_feature_control_d = ext_feature_control_q;
        int_mask_d            = int_mask_q;
        int_clear             = '0;
        if (data_write && addr_q == OFS_EXT_FEATURE) begin
            ext_feature_control_d = hwdata[7:0];
        end
        if (data_write && addr_q == OFS_INT_MASK) begin
            int_mask_d = hwdata[IRQ_WIDTH-1:0];
        end
        if (data_write && addr_q == OFS_INT_STATUS) begin
            int_clear = hwdata[IRQ_WIDTH-1:0];
        end
        gate_d = ext_feature_control_d[EXT_COUNT_GATE_BIT];
    end

    // Control register storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_feature_control_q <= RST_EXT_FEATURE;
            int_mask_q            <= RST_INT_MASK;
            gate_q                <= RST_EXT_FEATURE[EXT_COUNT_GATE_BIT];
        end else begin
            ext_feature_control_q <= ext_feature_control_d;
            int_mask_q            <= int_mask_d;
            gate_q                <= gate_d;
        end
    end

    // ==========================================================
    // Interrupt events and output
    always_comb begin
        int_set                   = '0;
        int_set[IRQ_OVERFLOW_BIT] = status_fifo_overflow & ~overflow_q; // Overflow onset
        int_set[IRQ_FRAME_BIT]    = frame_done;
    end

    frs_sticky #(
        .WIDTH (IRQ_WIDTH)
    ) u_int_status (
        .hclk    (hclk),
        .hresetn (hresetn),
        .set     (int_set),
        .clear   (int_clear),
        .flags   (int_status)
    );

    // Level interrupt from unmasked sticky bits
    always_comb begin
        irq_d = |(int_status & int_mask_q);
    end

    // Interrupt register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // ==========================================================
    // Output drive
    assign hrdata     = rdata_q;
    assign hreadyout  = ready_q;
    assign hresp      = resp_q;
    assign irq        = irq_q;
    assign count_gate = gate_q;

endmodule

/* frs_readback_properties.sv */
// Checker of bus timing and readback fields of the frame status block
`timescale 1ns/1ns
module frs_readback_properties
    import frs_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        irq,
    input wire logic        count_gate,
    input wire logic [3:0]  tx_char_bits,
    input wire logic [13:0] frame_byte_count,
    input wire logic        frame_done,
    input wire logic        status_fifo_overflow,
    input wire logic        status_fifo_available,
    input wire logic [7:0]  vector_readback,
    input wire logic [7:0]  pending_interrupt_readback
);
    logic        p1_q, p2_q, w1_q, w2_q, acc, rd_done;
    logic [7:0]  a1_q, a2_q;
    logic [13:0] cnt_q, cnt_p_q;
    // ==========================================================
    // Transfer pipeline and captured count
    assign acc = hsel && hready && htrans[1];
    assign rd_done = p2_q && !w2_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {p2_q, w2_q, a2_q, p1_q, w1_q, a1_q} <= '0;
            cnt_q <= '0;
            cnt_p_q <= '0;
        end else begin
            {p2_q, w2_q, a2_q, p1_q, w1_q, a1_q} <= {p1_q, w1_q, a1_q, acc, hwrite, haddr[7:0]};
            cnt_p_q <= cnt_q; // Count as seen when the read data was formed
            if (frame_done) cnt_q <= frame_byte_count;
        end
    end
    // Length code expected for a bit count
    function automatic logic [1:0] len_code(input logic [3:0] n);
        return (n <= 4'h5) ? LEN_CODE_5 : (n == 4'h6) ? LEN_CODE_6 : (n == 4'h7) ? LEN_CODE_7 : LEN_CODE_8;
    endfunction
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==========================================================
    // Assertions
    AST_ONE_WAIT: assert property (acc |=> !hreadyout ##1 hreadyout)
        else $error("transfer did not take exactly one wait state");
    AST_LEN_CODE: assert property (rd_done && a2_q == OFS_TX_CONFIG |-> hrdata[6:5] == len_code($past(tx_char_bits)))
        else $error("wrong character length code");
    AST_OVF_BIT: assert property (rd_done && a2_q == OFS_STATUS_HIGH && count_gate
        |-> hrdata[7] == !$past(status_fifo_overflow, 2))
        else $error("wrong overflow bit");
    AST_SRC_BIT: assert property (rd_done && a2_q == OFS_STATUS_HIGH && count_gate
        |-> hrdata[6] == !$past(status_fifo_available, 2))
        else $error("wrong status source bit");
    AST_VEC_GATE: assert property (rd_done && a2_q == OFS_COUNT_LOW && !count_gate
        |-> hrdata == {24'h0, $past(vector_readback)})
        else $error("gated low count read not vector");
    AST_PEND_GATE: assert property (rd_done && a2_q == OFS_STATUS_HIGH && !count_gate
        |-> hrdata == {24'h0, $past(pending_interrupt_readback)})
        else $error("gated high count read not pending");
    AST_CNT_LOW: assert property (rd_done && a2_q == OFS_COUNT_LOW && count_gate |-> hrdata[7:0] == cnt_p_q[7:0])
        else $error("wrong low count byte");
    AST_CNT_HIGH: assert property (rd_done && a2_q == OFS_STATUS_HIGH && count_gate |-> hrdata[5:0] == cnt_p_q[13:8])
        else $error("wrong high count bits");
    COV_CNT_READ: cover property (rd_done && count_gate);
    COV_IRQ: cover property ($rose(irq));
    COV_FRAME: cover property (frame_done);
endmodule
bind frs_readback frs_readback_properties frs_readback_properties_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hready, .hrdata, .hreadyout, .irq, .count_gate, .tx_char_bits, .frame_byte_count, .frame_done,
    .status_fifo_overflow, .status_fifo_available, .vector_readback, .pending_interrupt_readback);

/* frs_readback_test.sv */
// Self-checking testbench of the frame status readback block
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module frs_readback_test;
    import frs_pkg::*;
    localparam logic [1:0] LEN_WANT [0:5] = '{LEN_CODE_5, LEN_CODE_5, LEN_CODE_6, LEN_CODE_7, LEN_CODE_8, LEN_CODE_8};
    logic        hclk = 1'b0, hresetn, hsel, hwrite, hreadyout, hresp, irq, count_gate, frame_done;
    logic        tx_dtr, tx_send_break, tx_enable, tx_crc16_sel, tx_rts, tx_crc_enable;
    logic        status_fifo_overflow, status_fifo_available;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  tx_char_bits;
    logic [13:0] frame_byte_count;
    logic [7:0]  vector_readback, pending_interrupt_readback;
    int          err_count = 0, n_compared = 0;
    // ==========================================================
    // Clock, host model and design
    always #2 hclk = ~hclk;
    frs_host frs_host_i (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
    frs_readback frs_readback_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq, .count_gate, .tx_dtr, .tx_char_bits, .tx_send_break,
        .tx_enable, .tx_crc16_sel, .tx_rts, .tx_crc_enable, .frame_byte_count, .frame_done, .status_fifo_overflow,
        .status_fifo_available, .vector_readback, .pending_interrupt_readback);
    // ==========================================================
    // Shared tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        frs_host_i.xfer(1'b1, a, d, rdat);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
        frs_host_i.xfer(1'b0, a, 32'h0, rdat);
        `CHK(rdat, want)
        `CHK(hresp, 1'b0)
    endtask
    task automatic pulse(input logic [13:0] c);
        @(posedge hclk);
        frame_byte_count <= c;
        frame_done <= 1'b1;
        @(posedge hclk);
        frame_done <= 1'b0;
        frame_byte_count <= ~c;
    endtask
    task automatic wait_chk_irq(input logic want);
        repeat (3) @(posedge hclk);
        `CHK(irq, want)
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        rdchk(OFS_EXT_FEATURE, 32'h0);
        rdchk(OFS_INT_MASK, 32'h0);
        rdchk(OFS_INT_STATUS, 32'h0);
        rdchk(8'h20, 32'h0);
        `CHK(count_gate, 1'b0)
        $display("reset test done");
    endtask
    task automatic t_len;
        for (int i = 0; i < 6; i++) begin
            @(posedge hclk);
            tx_char_bits <= 4'(i + 4);
            frs_host_i.xfer(1'b0, OFS_TX_CONFIG, 32'h0, rdat);
            `CHK(rdat[6:5], LEN_WANT[i])
            `CHK({rdat[7], rdat[4:0]}, 6'h2a)
        end
        $display("length test done");
    endtask
    task automatic t_gate;
        rdchk(OFS_COUNT_LOW, 32'h5a);
        rdchk(OFS_STATUS_HIGH, 32'h3c);
        wr(OFS_EXT_FEATURE, 32'h4);
        `CHK(count_gate, 1'b1)
        rdchk(OFS_COUNT_LOW, 32'h0);
        rdchk(OFS_STATUS_HIGH, 32'hc0);
        $display("gate test done");
    endtask
    task automatic t_count;
        pulse(14'h3f5b);
        rdchk(OFS_COUNT_LOW, 32'h5b);
        wr(OFS_COUNT_LOW, 32'h0);
        rdchk(OFS_COUNT_LOW, 32'h5b);
        for (int i = 0; i < 4; i++) begin
            @(posedge hclk);
            {status_fifo_overflow, status_fifo_available} <= 2'(i);
            rdchk(OFS_STATUS_HIGH, {24'h0, ~2'(i), 6'h3f});
        end
        $display("count test done");
    endtask
    task automatic t_irq;
        wr(OFS_INT_STATUS, 32'h3);
        wr(OFS_INT_MASK, 32'h1);
        pulse(14'h0001);
        wait_chk_irq(1'b0);
        rdchk(OFS_INT_STATUS, 32'h2);
        wr(OFS_INT_MASK, 32'h3);
        wait_chk_irq(1'b1);
        wr(OFS_INT_STATUS, 32'h2);
        wait_chk_irq(1'b0);
        rdchk(OFS_INT_STATUS, 32'h0);
        $display("interrupt test done");
    endtask
    // ==========================================================
    // Verdict, watchdog and main sequence
    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #40000;
        err_count++;
        test_done();
    end
    initial begin
        hresetn = 1'b0;
        {tx_dtr, tx_send_break, tx_enable, tx_crc16_sel, tx_rts, tx_crc_enable} = 6'h2a;
        {tx_char_bits, frame_byte_count, frame_done} = '0;
        {status_fifo_overflow, status_fifo_available} = 2'h0;
        vector_readback = 8'h5a;
        pending_interrupt_readback = 8'h3c;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_len();
        t_gate();
        t_count();
        t_irq();
        test_done();
    end
endmodule

/* frs_sticky.sv */
// Sticky event flags with write-one-to-clear, set winning over clear
`timescale 1ns/1ns
module frs_sticky #(
    parameter int WIDTH = 2
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] set,
    input  wire logic [WIDTH-1:0] clear,
    output logic      [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] flags_q;
    logic [WIDTH-1:0] flags_d;

    // Elaboration check on width
    if (WIDTH < 1) begin : g_bad_width
        $error("frs_sticky: WIDTH must be at least 1");
    end

    // Next flags: a set in the clear cycle survives
    always_comb begin
        flags_d = (flags_q & ~clear) | set;
    end

    // Flag storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags = flags_q;

endmodule
